/* common/dpac_pkg.sv */
// Constants and types for the dual process alarm comparator
package dpac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CH = 2;                             // Alarm channels
  localparam int RATE_W = 20;                            // Rate value width
  localparam int TOT_W  = 27;                            // Total value width
  localparam int SEC_W  = 12;                            // Seconds width

  ////////////////////////////////////////////////////////////////////////////
  // Limits
  localparam logic [TOT_W-1:0] RATE_SP_MAX  = 27'h00F423F; // 999999
  localparam logic [TOT_W-1:0] TOTAL_SP_MAX = 27'h5F5E0FF; // 99999999
  localparam logic [SEC_W-1:0] MAX_SECONDS  = 12'hE10;     // 3600 s

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ       = 10000000;                // System clock rate
  localparam int HALF_SEC_MS  = 500;                     // Sample period, ms
  localparam int HALF_SEC_CYC = CLK_HZ / 1000 * HALF_SEC_MS; // Cycles
  localparam int DIV_W        = 23;                      // Divider width

  ////////////////////////////////////////////////////////////////////////////
  // Configuration field select for the write port
  typedef enum logic [3:0] {
    FLD_ENABLE, FLD_SOURCE, FLD_SENSE, FLD_OUTPUT, FLD_SETPOINT,
    FLD_HYST, FLD_DELAY, FLD_SILENCE, FLD_ACC_EN, FLD_ACC_CODE
  } dpac_field_t;

  // Per-channel stored configuration
  typedef struct packed {
    logic               enable;      // Alarm operation on
    logic               srcTotal;    // 1 total, 0 rate
    logic               senseLow;    // 1 low alarm, 0 high alarm
    logic               normClosed;  // 1 closed while no alarm
    logic [TOT_W-1:0]   setpoint;    // Trip value
    logic [RATE_W-1:0]  hyst;        // Rate hysteresis
    logic [SEC_W-1:0]   delay;       // Activation delay, seconds
    logic [SEC_W-1:0]   silence;     // Silence duration, seconds
  } dpac_cfg_t;

  // Values after reset; the configuration default also after a source change
  localparam dpac_cfg_t CFG_DEFAULT = '0;
  localparam logic [15:0] ACC_CODE_DEFAULT = 16'h0000;

endpackage

/* common/dpac_chan_if.sv */
// Carrier between the alarm top and one channel comparator
interface dpac_chan_if;
  import dpac_pkg::*;
  dpac_cfg_t         cfg;           // Channel configuration
  logic [RATE_W-1:0] rateValue;     // Live scaled rate
  logic [TOT_W-1:0]  totalSample;   // Total sampled twice a second
  logic              secTick;       // One-second enable pulse
  logic              flashPhase;    // Annunciator blink phase
  logic              accept;        // Operator accept pulse
  logic              switchClosed;  // Switch state wanted
  logic              annunOn;       // Annunciator lit wanted

  modport top  (output cfg, rateValue, totalSample, secTick, flashPhase, accept,
                input  switchClosed, annunOn);
  modport chan (input  cfg, rateValue, totalSample, secTick, flashPhase, accept,
                output switchClosed, annunOn);
endinterface

/* verilog/dpac_channel.sv */
// One alarm channel: comparison, hysteresis, delay and silence timing
module dpac_channel
  import dpac_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  dpac_chan_if.chan ch
);

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ACTIVE, ST_SILENCED} dpac_state_t;

  dpac_state_t       state_reg;      // Channel state
  logic [SEC_W-1:0]  secCnt_reg;     // Elapsed seconds
  logic              cond_reg;       // Latched alarm condition
  logic [TOT_W-1:0]  cmpVal;         // Value under comparison
  logic [TOT_W:0]    hystEff;        // Effective hysteresis
  logic              enter;          // Condition newly met
  logic              stay;           // Condition still held
  logic [SEC_W-1:0]  secCntInc;      // Seconds plus one

  ////////////////////////////////////////////////////////////////////////////
  // Comparison
  always_comb begin
    // Pick rate or sampled total
    cmpVal = ch.cfg.srcTotal ? ch.totalSample : {7'h00, ch.rateValue};
    // Total channels see no hysteresis
    hystEff = ch.cfg.srcTotal ? 28'h0000000 : {8'h00, ch.cfg.hyst};
    if (ch.cfg.senseLow) begin
      // Low: at or below, released above setpoint plus hysteresis
      enter = cmpVal <= ch.cfg.setpoint;
      stay  = {1'b0, cmpVal} <= {1'b0, ch.cfg.setpoint} + hystEff;
    end else begin
      // High: at or above, released below setpoint minus hysteresis
      enter = cmpVal >= ch.cfg.setpoint;
      stay  = {1'b0, cmpVal} + hystEff >= {1'b0, ch.cfg.setpoint};
    end
    secCntInc = secCnt_reg + 12'h001;
  end

  // Hysteresis memory, cleared while disabled
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cond_reg <= 1'b0;
    end else if (!ch.cfg.enable) begin
      cond_reg <= 1'b0;
    end else begin
      cond_reg <= cond_reg ? stay : enter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay and silence state machine
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ST_IDLE;
      secCnt_reg <= 12'h000;
    end else if (!ch.cfg.enable || !cond_reg) begin
      // Condition gone: timers restart next time
      state_reg  <= ST_IDLE;
      secCnt_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Zero delay goes straight to alarm
          secCnt_reg <= 12'h000;
          state_reg  <= (ch.cfg.delay == 12'h000) ? ST_ACTIVE : ST_DELAY;
        end
        ST_DELAY: begin
          // Count whole seconds of delay
          if (ch.secTick) begin
            secCnt_reg <= secCntInc;
            if (secCntInc >= ch.cfg.delay) begin
              state_reg <= ST_ACTIVE;
            end
          end
        end
        ST_ACTIVE: begin
          // Accept only with a silence time
          if (ch.accept && ch.cfg.silence != 12'h000) begin
            state_reg  <= ST_SILENCED;
            secCnt_reg <= 12'h000;
          end
        end
        default: begin
          // Silenced: count seconds up to the silence time, then re-alarm
          if (ch.secTick) begin
            secCnt_reg <= secCntInc;
            if (secCntInc >= ch.cfg.silence) begin
              state_reg <= ST_ACTIVE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wants
  always_comb begin
    // Normally closed inverts the switch
    ch.switchClosed = (state_reg == ST_ACTIVE) ^ ch.cfg.normClosed;
    // Steady when alarming, blinking while timing
    ch.annunOn = (state_reg == ST_ACTIVE) ||
                 ((state_reg == ST_DELAY || state_reg == ST_SILENCED)
                  && ch.flashPhase);
  end

endmodule // dpac_channel

/* verilog/dpac_alarm_top.sv */
// Dual process alarm comparator: configuration store, timebase, outputs
module dpac_alarm_top
  import dpac_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = HALF_SEC_CYC  // Cycles per half second
)(
  input  wire logic              clock,
  input  wire logic              resetn,
  // Process values from the rate and total computation
  input  wire logic [RATE_W-1:0] rateValue,
  input  wire logic [TOT_W-1:0]  totalValue,
  // Scaling recalibrated, one-cycle pulse
  input  wire logic              recalPulse,
  // Operator accept button, asynchronous pin
  input  wire logic              acceptPin,
  // Programme write port
  input  wire logic              wrEn,
  input  wire logic              wrChan,
  input  wire dpac_field_t       wrField,
  input  wire logic [TOT_W-1:0]  wrData,
  // Direct setpoint access port
  input  wire logic              dsWr,
  input  wire logic              dsChan,
  input  wire logic [15:0]       dsCode,
  input  wire logic [TOT_W-1:0]  dsData,
  // Outputs
  output logic [NUM_CH-1:0]      switchClosed,
  output logic [NUM_CH-1:0]      annunciator,
  output logic [NUM_CH-1:0]      channelEnabled,
  output logic [NUM_CH-1:0]      channelTotal,
  output logic                   dsAccepted,
  output logic                   dsRefused
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]        rstSync_reg;     // Reset release stages
  logic              rstn;            // Synchronised reset
  logic [2:0]        accSync_reg;     // Accept pin sync and edge
  logic              acceptPulse;     // Accept rising edge
  logic [DIV_W-1:0]  divCnt_reg;      // Half-second divider
  logic              halfTick;        // Half-second enable
  logic              flashPhase_reg;  // Toggles each half second
  logic              secTick;         // One-second enable
  logic [TOT_W-1:0]  totalSample_reg; // Sampled total
  dpac_cfg_t         cfg_reg [NUM_CH];// Stored configuration
  logic              accEnable_reg;   // Direct access allowed
  logic [15:0]       accCode_reg;     // Direct access code
  logic              srcChange;       // Source write changes source
  logic [TOT_W-1:0]  wrSpLimit;       // Setpoint ceiling for write
  logic [TOT_W-1:0]  wrSpClamped;     // Clamped write setpoint
  logic [TOT_W-1:0]  dsSpLimit;       // Setpoint ceiling, direct
  logic [TOT_W-1:0]  dsSpClamped;     // Clamped direct setpoint
  logic [SEC_W-1:0]  wrSecClamped;    // Clamped seconds value
  logic              dsOk;            // Direct write allowed

  dpac_chan_if chIf [NUM_CH] ();      // One carrier per channel

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstn = rstSync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Accept pin: two-stage sync then edge detect on later stages
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      accSync_reg <= 3'h0;
    end else begin
      accSync_reg <= {accSync_reg[1:0], acceptPin};
    end
  end
  assign acceptPulse = accSync_reg[1] & ~accSync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: half-second tick, one-second tick, blink phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= '0;
    end else if (halfTick) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_reg + 23'h000001;
    end
  end
  assign halfTick = (divCnt_reg == DIV_W'(HALF_SEC_CYCLES - 1));

  // Blink phase doubles as second divider
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flashPhase_reg <= 1'b0;
    end else if (halfTick) begin
      flashPhase_reg <= ~flashPhase_reg;
    end
  end
  assign secTick = halfTick & flashPhase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Total sampled twice per second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      totalSample_reg <= '0;
    end else if (halfTick) begin
      totalSample_reg <= totalValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write value conditioning
  always_comb begin
    // Setpoint range depends on channel source
    wrSpLimit   = cfg_reg[wrChan].srcTotal ? TOTAL_SP_MAX : RATE_SP_MAX;
    wrSpClamped = (wrData > wrSpLimit) ? wrSpLimit : wrData;
    dsSpLimit   = cfg_reg[dsChan].srcTotal ? TOTAL_SP_MAX : RATE_SP_MAX;
    dsSpClamped = (dsData > dsSpLimit) ? dsSpLimit : dsData;
    // Delay and silence capped at the maximum
    if (wrData > {15'h0000, MAX_SECONDS}) begin
      wrSecClamped = MAX_SECONDS;
    end else begin
      wrSecClamped = wrData[SEC_W-1:0];
    end
    // Source write that actually changes the source
    srcChange = wrEn && wrField == FLD_SOURCE &&
                wrData[0] != cfg_reg[wrChan].srcTotal;
    // Direct path needs enable and matching or zero code
    dsOk = dsWr && accEnable_reg &&
           (accCode_reg == 16'h0000 || accCode_reg == dsCode);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel configuration store
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_reg[i] <= CFG_DEFAULT;
      end
    end else begin
      // Programme writes
      if (wrEn) begin
        case (wrField)
          FLD_ENABLE:   cfg_reg[wrChan].enable     <= wrData[0];
          FLD_SENSE:    cfg_reg[wrChan].senseLow   <= wrData[0];
          FLD_OUTPUT:   cfg_reg[wrChan].normClosed <= wrData[0];
          FLD_SETPOINT: cfg_reg[wrChan].setpoint   <= wrSpClamped;
          FLD_HYST:     cfg_reg[wrChan].hyst       <= wrData[RATE_W-1:0];
          FLD_DELAY:    cfg_reg[wrChan].delay      <= wrSecClamped;
          FLD_SILENCE:  cfg_reg[wrChan].silence    <= wrSecClamped;
          default: begin
            // Source handled below, access fields elsewhere
          end
        endcase
      end
      // Direct setpoint write
      if (dsOk) begin
        cfg_reg[dsChan].setpoint <= dsSpClamped;
      end
      // Recalibration disables both channels
      if (recalPulse) begin
        for (int i = 0; i < NUM_CH; i++) begin
          cfg_reg[i].enable <= 1'b0;
        end
      end
      // Source change: defaults, new source, both disabled
      if (srcChange) begin
        for (int i = 0; i < NUM_CH; i++) begin
          cfg_reg[i].enable <= 1'b0;
        end
        cfg_reg[wrChan]          <= CFG_DEFAULT;
        cfg_reg[wrChan].srcTotal <= wrData[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct access settings
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      accEnable_reg <= 1'b0;
      accCode_reg   <= ACC_CODE_DEFAULT;
    end else if (wrEn && wrField == FLD_ACC_EN) begin
      accEnable_reg <= wrData[0];
    end else if (wrEn && wrField == FLD_ACC_CODE) begin
      accCode_reg   <= wrData[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct access answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dsAccepted <= 1'b0;
      dsRefused  <= 1'b0;
    end else begin
      dsAccepted <= dsOk;
      dsRefused  <= dsWr && !dsOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two identical channels
  for (genvar g = 0; g < NUM_CH; g++) begin : gCh
    assign chIf[g].cfg         = cfg_reg[g];
    assign chIf[g].rateValue   = rateValue;
    assign chIf[g].totalSample = totalSample_reg;
    assign chIf[g].secTick     = secTick;
    assign chIf[g].flashPhase  = flashPhase_reg;
    assign chIf[g].accept      = acceptPulse;

    dpac_channel uChan (
      .clock (clock),
      .rstn  (rstn),
      .ch    (chIf[g].chan)
    );

    // Registered outputs
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        switchClosed[g]   <= 1'b0;
        annunciator[g]    <= 1'b0;
        channelEnabled[g] <= 1'b0;
        channelTotal[g]   <= 1'b0;
      end else begin
        switchClosed[g]   <= chIf[g].switchClosed;
        annunciator[g]    <= chIf[g].annunOn;
        channelEnabled[g] <= cfg_reg[g].enable;
        channelTotal[g]   <= cfg_reg[g].srcTotal;
      end
    end
  end

endmodule // dpac_alarm_top

/* test/dpac_alarm_load.sv */
// Model of the external alarm loop wired to the two switch outputs
module dpac_alarm_load
  import dpac_pkg::*;
(
  input  wire logic [NUM_CH-1:0] switchClosed,  // Switch states from the block
  output logic      [NUM_CH-1:0] loadOn         // Loop current flowing
);
  //////////////////////////////////////////////////////////////////////////////
  // Polarised loop: current only through a closed switch, an open one passes none
  assign loadOn = switchClosed;
endmodule // dpac_alarm_load

/* test/dpac_alarm_top_assertions.sv */
// Concurrent checks on the alarm comparator top ports
module dpac_alarm_top_chk
  import dpac_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = 10  // Cycles per half second
)(
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic [RATE_W-1:0] rateValue,
  input wire logic [TOT_W-1:0]  totalValue,
  input wire logic              recalPulse,
  input wire logic              acceptPin,
  input wire logic              wrEn,
  input wire logic              wrChan,
  input wire dpac_field_t       wrField,
  input wire logic [TOT_W-1:0]  wrData,
  input wire logic              dsWr,
  input wire logic              dsChan,
  input wire logic [15:0]       dsCode,
  input wire logic [TOT_W-1:0]  dsData,
  input wire logic [NUM_CH-1:0] switchClosed,
  input wire logic [NUM_CH-1:0] annunciator,
  input wire logic [NUM_CH-1:0] channelEnabled,
  input wire logic [NUM_CH-1:0] channelTotal,
  input wire logic              dsAccepted,
  input wire logic              dsRefused
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  // Direct setpoint port answers once, and only when asked
  a_ds_answer: assert property (dsWr |=> dsAccepted ^ dsRefused)
    else $error("direct write not answered exactly once");
  a_ds_quiet: assert property (!dsWr |=> !dsAccepted && !dsRefused)
    else $error("direct write answer without request");
  //////////////////////////////////////////////////////////////////////////////
  // Outputs open while held in reset, as with power removed
  a_reset_open: assert property ($rose(resetn) |->
    switchClosed == 2'h0 && annunciator == 2'h0)
    else $error("switch or annunciator active out of reset");
  //////////////////////////////////////////////////////////////////////////////
  // Enable handling
  a_recal_clear: assert property (recalPulse |-> ##2 channelEnabled == 2'h0)
    else $error("recalibration left an enable set");
  a_enable_set: assert property (wrEn && wrField == FLD_ENABLE && wrData[0] && !recalPulse
    ##1 !recalPulse && !wrEn |-> ##1 channelEnabled[$past(wrChan, 2)])
    else $error("enable write not stored");
  a_disabled_dark: assert property ((channelEnabled == 2'h0) [*4] |-> annunciator == 2'h0)
    else $error("annunciator lit on disabled channels");
  //////////////////////////////////////////////////////////////////////////////
  // Source selection
  a_source_show: assert property (wrEn && wrField == FLD_SOURCE
    |-> ##2 channelTotal[$past(wrChan, 2)] == $past(wrData[0], 2))
    else $error("source selection not reflected");
  a_source_clear: assert property (wrEn && wrField == FLD_SOURCE
    && wrData[0] != channelTotal[wrChan] |-> ##2 channelEnabled == 2'h0)
    else $error("source change left an enable set");
endmodule // dpac_alarm_top_chk

bind dpac_alarm_top dpac_alarm_top_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_dpac_alarm_top_chk (
  .clock(clock), .resetn(resetn), .rateValue(rateValue), .totalValue(totalValue),
  .recalPulse(recalPulse), .acceptPin(acceptPin), .wrEn(wrEn), .wrChan(wrChan),
  .wrField(wrField), .wrData(wrData), .dsWr(dsWr), .dsChan(dsChan), .dsCode(dsCode),
  .dsData(dsData), .switchClosed(switchClosed), .annunciator(annunciator),
  .channelEnabled(channelEnabled), .channelTotal(channelTotal),
  .dsAccepted(dsAccepted), .dsRefused(dsRefused));

/* test/dpac_alarm_top_tb.sv */
// Self-checking bench for the dual process alarm comparator
module dpac_alarm_top_tb
  import dpac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic low; logic [RATE_W-1:0] rate; logic exp;} dpac_row_t;
  logic clock = 1'b0, resetn = 1'b0, recalPulse = 1'b0, acceptPin = 1'b0;  // Controls
  logic wrEn = 1'b0, wrChan = 1'b0, dsWr = 1'b0, dsChan = 1'b0;         // Strobes
  dpac_field_t       wrField = FLD_ENABLE;                               // Field select
  logic [RATE_W-1:0] rateValue = '0;                                     // Rate stimulus
  logic [TOT_W-1:0]  totalValue = '0, wrData = '0, dsData = '0;          // Data stimulus
  logic [15:0]       dsCode = '0;                                        // Offered code
  logic [NUM_CH-1:0] switchClosed, annunciator, channelEnabled, channelTotal, loadOn;
  logic              dsAccepted, dsRefused, acc, rej;                    // Direct answers
  int                errors = 0, num_checks = 0, cycles = 0, cnt;        // Bookkeeping
  // High and low sense rows against setpoint 1000, no hysteresis
  dpac_row_t rows [7] = '{'{1'b0, 20'h003E7, 1'b0}, '{1'b0, 20'h003E8, 1'b1},
    '{1'b0, 20'h005DC, 1'b1}, '{1'b1, 20'h005DC, 1'b0}, '{1'b1, 20'h003E8, 1'b1},
    '{1'b1, 20'h001F4, 1'b1}, '{1'b1, 20'h003E9, 1'b0}};
  //////////////////////////////////////////////////////////////////////////////
  // Design and alarm loop
  dpac_alarm_top #(.HALF_SEC_CYCLES(10)) i_dpac_alarm_top (.clock(clock), .resetn(resetn),
    .rateValue(rateValue), .totalValue(totalValue), .recalPulse(recalPulse),
    .acceptPin(acceptPin), .wrEn(wrEn), .wrChan(wrChan), .wrField(wrField), .wrData(wrData),
    .dsWr(dsWr), .dsChan(dsChan), .dsCode(dsCode), .dsData(dsData),
    .switchClosed(switchClosed), .annunciator(annunciator), .channelEnabled(channelEnabled),
    .channelTotal(channelTotal), .dsAccepted(dsAccepted), .dsRefused(dsRefused));
  dpac_alarm_load i_dpac_alarm_load (.switchClosed(switchClosed), .loadOn(loadOn));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic c, input dpac_field_t f, input logic [TOT_W-1:0] d);
    @(negedge clock);
    wrEn = 1'b1;
    wrChan = c;
    wrField = f;
    wrData = d;
    @(negedge clock);
    wrEn = 1'b0;
  endtask
  // Direct write; answer gathered over the two following cycles
  task automatic ds(input logic [15:0] k, input logic [TOT_W-1:0] d);
    @(negedge clock);
    dsWr = 1'b1;
    dsCode = k;
    dsData = d;
    @(negedge clock);
    dsWr = 1'b0;
    acc = dsAccepted;
    rej = dsRefused;
    @(negedge clock);
    acc = acc | dsAccepted;
    rej = rej | dsRefused;
  endtask
  task automatic press();
    acceptPin = 1'b1;
    tick(5);
    acceptPin = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    tick(4);
    chk("reset", {switchClosed, annunciator, channelEnabled, channelTotal}, 32'h0);
    wr(1'b0, FLD_SETPOINT, 27'h00003E8);
    wr(1'b0, FLD_ENABLE, 27'h1);
    tick(3);
    chk("enable", channelEnabled, 32'h1);
    // Table of sense and value rows on the rate channel
    foreach (rows[i]) begin
      wr(1'b0, FLD_SENSE, {26'h0, rows[i].low});
      rateValue = rows[i].rate;
      tick(6);
      chk("load", loadOn[0], rows[i].exp);
      chk("annun", annunciator[0], rows[i].exp);
    end
    // Disable keeps parameters
    wr(1'b0, FLD_SENSE, 27'h0);
    rateValue = 20'h005DC;
    wr(1'b0, FLD_ENABLE, 27'h0);
    tick(6);
    chk("off", loadOn[0], 32'h0);
    wr(1'b0, FLD_ENABLE, 27'h1);
    tick(6);
    chk("on", loadOn[0], 32'h1);
    // Normally closed output opens in alarm
    wr(1'b0, FLD_OUTPUT, 27'h1);
    tick(6);
    chk("nc alarm", switchClosed[0], 32'h0);
    rateValue = 20'h0;
    tick(6);
    chk("nc idle", switchClosed[0], 32'h1);
    wr(1'b0, FLD_OUTPUT, 27'h0);
    // Hysteresis release boundary
    wr(1'b0, FLD_HYST, 27'h64);
    rateValue = 20'h003E8;
    tick(6);
    rateValue = 20'h00384;
    tick(6);
    chk("hyst hold", loadOn[0], 32'h1);
    rateValue = 20'h00383;
    tick(6);
    chk("hyst free", loadOn[0], 32'h0);
    wr(1'b0, FLD_HYST, 27'h0);
    // Setpoint clamped to the rate ceiling
    wr(1'b0, FLD_SETPOINT, 27'h7FFFFFF);
    rateValue = 20'hF423F;
    tick(6);
    chk("clamp", loadOn[0], 32'h1);
    rateValue = 20'hF423E;
    tick(6);
    chk("below max", loadOn[0], 32'h0);
    // Activation delay of two seconds, annunciator blinking meanwhile
    rateValue = 20'h0;
    wr(1'b0, FLD_SETPOINT, 27'h00003E8);
    wr(1'b0, FLD_DELAY, 27'h2);
    rateValue = 20'h005DC;
    cnt = 0;
    for (int i = 0; i < 15; i++) begin
      tick(1);
      cnt += int'(annunciator[0] === 1'b1);
    end
    chk("in delay", loadOn[0], 32'h0);
    chk("blink", (cnt > 0) && (cnt < 15), 32'h1);
    tick(35);
    chk("delayed", {annunciator[0], loadOn[0]}, 32'h3);
    // Accept refused with zero silence, then silence of two seconds
    wr(1'b0, FLD_DELAY, 27'h0);
    press();
    tick(8);
    chk("no silence", loadOn[0], 32'h1);
    wr(1'b0, FLD_SILENCE, 27'h2);
    press();
    tick(8);
    chk("silenced", loadOn[0], 32'h0);
    // Annunciator blinks while silenced, still before expiry
    cnt = 0;
    for (int i = 0; i < 11; i++) begin
      tick(1);
      cnt += int'(annunciator[0] === 1'b1);
    end
    chk("silence blink", (cnt > 0) && (cnt < 11), 32'h1);
    tick(39);
    chk("re-alarm", loadOn[0], 32'h1);
    // Source change on channel one clears both enables and loads defaults
    wr(1'b1, FLD_SOURCE, 27'h1);
    tick(3);
    chk("source", {channelTotal, channelEnabled}, 32'h8);
    wr(1'b1, FLD_ENABLE, 27'h1);
    tick(20);
    chk("defaults", loadOn, 32'h2);
    // Total channel ignores hysteresis
    wr(1'b1, FLD_SETPOINT, 27'h0001388);
    wr(1'b1, FLD_HYST, 27'h64);
    totalValue = 27'h0001387;
    tick(20);
    chk("tot below", loadOn[1], 32'h0);
    totalValue = 27'h0001388;
    tick(20);
    chk("tot equal", loadOn[1], 32'h1);
    totalValue = 27'h0001356;
    tick(20);
    chk("tot no hyst", loadOn[1], 32'h0);
    // Recalibration clears both enables, source kept
    wr(1'b0, FLD_ENABLE, 27'h1);
    tick(3);
    recalPulse = 1'b1;
    tick(1);
    recalPulse = 1'b0;
    tick(3);
    chk("recal", {channelTotal, channelEnabled}, 32'h8);
    // Direct setpoint access: off, open code, wrong code
    ds(16'h0000, 27'h00003E8);
    chk("ds off", {acc, rej}, 32'h1);
    wr(1'b0, FLD_ACC_EN, 27'h1);
    ds(16'h5555, 27'h00007D0);
    chk("ds open", {acc, rej}, 32'h2);
    wr(1'b0, FLD_ACC_CODE, 27'h1234);
    ds(16'h1235, 27'h00003E8);
    chk("ds wrong", {acc, rej}, 32'h1);
    wr(1'b0, FLD_ENABLE, 27'h1);
    rateValue = 20'h007CF;
    tick(6);
    chk("ds sp low", loadOn[0], 32'h0);
    rateValue = 20'h007D0;
    tick(6);
    chk("ds sp hit", loadOn[0], 32'h1);
    // Direct write to the total channel, clamped to the total ceiling
    dsChan = 1'b1;
    ds(16'h1234, 27'h7FFFFFF);
    chk("ds ch1", {acc, rej}, 32'h2);
    wr(1'b1, FLD_ENABLE, 27'h1);
    totalValue = 27'h5F5E0FE;
    tick(20);
    chk("ds tot low", loadOn[1], 32'h0);
    totalValue = 27'h5F5E0FF;
    tick(20);
    chk("ds tot max", loadOn[1], 32'h1);
    stop_test();
  end
endmodule // dpac_alarm_top_tb
